// File: verilog/cps_cfg.svh
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH

// Time base.
`define CPS_CLK_PERIOD_NS   10
`define CPS_MS_NS           1000000
`define CPS_CYC_PER_MS      (`CPS_MS_NS / `CPS_CLK_PERIOD_NS)

// Register byte offsets.
`define CPS_OFF_CTRL        12'h000
`define CPS_OFF_SYNC        12'h004
`define CPS_OFF_GAP         12'h008
`define CPS_OFF_POLICY      12'h00C
`define CPS_OFF_STATUS      12'h010
`define CPS_OFF_DOUT        12'h014
`define CPS_OFF_AOUT        12'h018
`define CPS_OFF_VER0        12'h01C
`define CPS_OFF_VER1        12'h020
`define CPS_OFF_NETCNT      12'h024
`define CPS_OFF_DIN         12'h028
`define CPS_OFF_AIN         12'h02C

// Reset values.
`define CPS_SYNC_RST        16'h000A
`define CPS_GAP_RST         16'h0005
`define CPS_POLICY_RST      4'h0

// Error confinement thresholds and the network count limit.
`define CPS_PASSIVE_LIM     9'h07F
`define CPS_OFF_LIM         9'h0FF
`define CPS_TALLY_MAX       9'h1FF
`define CPS_NET_LIMIT       32'h00000001

`endif

// File: verilog/cps_pkg.sv
package cps_pkg;

	// Send policy per message.
	typedef enum logic {
		CPS_SYNCED  = 1'b0,
		CPS_CHANGED = 1'b1
	} cps_policy_type;

	// Bus state, one-hot.
	typedef enum logic [2:0] {
		CPS_BUS_OPER    = 3'b001,
		CPS_BUS_PASSIVE = 3'b010,
		CPS_BUS_OFF     = 3'b100
	} cps_bus_type;

	// Cycle phase, one-hot.
	typedef enum logic [2:0] {
		CPS_PH_WAIT = 3'b001,
		CPS_PH_OUT  = 3'b010,
		CPS_PH_IDLE = 3'b100
	} cps_phase_type;

endpackage

// File: verilog/cps_scheduler.sv
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "cps_cfg.svh"

// Operation
// [RL1] Send policy encodes periodic synchronized as 0, change-triggered as 1.
// [RL2] Four messages per node: digital in/out, analog in/out, policy each.
// [RL3] After reset all messages use periodic synchronized policy.
// [RL4] Master broadcasts a sync message regularly, each starts one cycle.
// [RL5] Sync spacing equals configured interval in whole milliseconds.
// [RL6] Periodic slaves latch and send inputs on each sync.
// [RL7] Outputs sent right after sync; nodes apply them at next sync.
// [RL8] Each cycle leaves idle time for non-periodic messages.
// [RL9] Software keeps sync interval above bit-rate and node-count minimum.
// [RL10] Change-triggered messages go only on data change, never on sync.
// [RL11] Change send on new slave input or new commanded master output.
// [RL12] Two successive data messages never closer than inhibit time; periodic outputs ignore it and both go out in one cycle.
// [RL13] Inhibit time is one millisecond value for the whole network.
// [RL14] Inhibit time is best about half the sync interval.
// [RL15] Transmit and receive error tallies count errors up, successes down.
// [RL16] Operational state takes full part, including error signalling.
// [RL17] Passive state detects errors but sends no active error flags.
// [RL18] Transmit tally above 255 enters bus-off, isolating the controller.
// [RL19] All parties share one standard bit rate, 1M down to 10k.
// [RL20] At most one network instance is supported.
// [RL21] Bootloader, firmware version, revision, subrevision are readable.
// [RL22] Error tallies and bus state readable as status; the status register shows only the low 8 bits of the receive tally.
// [RL23] Passive above 127 on either tally; operational when both at most 127.
module cps_scheduler #(
	parameter int CYC_PER_MS = `CPS_CYC_PER_MS,
	parameter logic [15:0] BOOT_VER = 16'h0001, // Arbitrary value.
	parameter logic [15:0] FW_VER   = 16'h0001, // Arbitrary value.
	parameter logic [7:0]  FW_REV   = 8'h01,    // Arbitrary value.
	parameter logic [15:0] FW_SUB   = 16'h0001  // Arbitrary value.
) (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Message transmit request to the CAN controller.
	output logic             sync_req,
	output logic             dout_req,
	output logic             aout_req,
	output logic      [31:0] dout_data,
	output logic      [31:0] aout_data,
	input  wire logic        tx_done,
	// Inputs received from the nodes.
	input  wire logic        din_rx,
	input  wire logic        ain_rx,
	input  wire logic [31:0] din_data,
	input  wire logic [31:0] ain_data,
	// Error events from the bit engine.
	input  wire logic        tx_err,
	input  wire logic        tx_ok,
	input  wire logic        rx_err,
	input  wire logic        rx_ok,
	// Bus participation controls.
	output logic             err_flag_en,
	output logic             bus_isolate
);

	// Register state.
	logic                 enable_q;
	logic [15:0]          sync_ms_q;
	logic [15:0]          gap_ms_q;
	logic [3:0]           policy_q;
	logic [31:0]          dout_q;
	logic [31:0]          aout_q;
	logic [31:0]          din_q;
	logic [31:0]          ain_q;
	logic                 dout_new_q;
	logic                 aout_new_q;
	logic [8:0]           tec_q;
	logic [8:0]           rec_q;
	cps_pkg::cps_bus_type   bus_q;
	cps_pkg::cps_phase_type phase_q;
	// Time base.
	logic [31:0]          tick_cnt_q;
	logic                 ms_tick;
	logic [15:0]          sync_cnt_q;
	logic [15:0]          gap_cnt_q;
	logic                 sync_due;
	logic                 gap_open;
	logic                 wr;
	logic                 rd;
	logic                 dout_chg;
	logic                 aout_chg;
	logic                 bus_ok;
	logic                 dout_send;
	logic                 aout_send;

	assign wr = psel && penable && pwrite;
	assign rd = psel && !pwrite;
	// A transmit tally past the bus-off limit blocks sends in the very cycle
	// that the state machine moves to bus-off, so no request leaks out.
	assign bus_ok = (bus_q != cps_pkg::CPS_BUS_OFF) &&
		(tec_q <= `CPS_OFF_LIM); // [RL18]
	// Change-triggered sends require a new value and an open inhibit gap.
	assign dout_chg = policy_q[1] == cps_pkg::CPS_CHANGED; // [RL1] [RL2]
	assign aout_chg = policy_q[3] == cps_pkg::CPS_CHANGED; // [RL2]
	assign gap_open = (gap_cnt_q == 16'h0000); // [RL12] [RL13]

	// Millisecond strobe from the system clock.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= 32'h00000000;
			ms_tick <= 1'b0;
		end else if (tick_cnt_q == 32'(CYC_PER_MS - 1)) begin
			tick_cnt_q <= 32'h00000000;
			ms_tick <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
			ms_tick <= 1'b0;
		end
	end

	// Sync interval counter, one sync per configured millisecond count.
	// An interval of zero behaves as one millisecond.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_cnt_q <= 16'h0000;
		end else if (!enable_q) begin
			sync_cnt_q <= 16'h0000;
		end else if (ms_tick) begin
			if (sync_cnt_q + 16'h0001 >= sync_ms_q) begin // [RL5]
				sync_cnt_q <= 16'h0000;
			end else begin
				sync_cnt_q <= sync_cnt_q + 16'h0001;
			end
		end
	end
	assign sync_due = enable_q && ms_tick && bus_ok &&
		(sync_cnt_q + 16'h0001 >= sync_ms_q); // [RL4]

	// Cycle phase: sync, then outputs, then one idle cycle, then wait for the next sync.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= cps_pkg::CPS_PH_WAIT;
		end else begin
			case (phase_q)
				cps_pkg::CPS_PH_WAIT: begin
					if (sync_due) begin
						phase_q <= cps_pkg::CPS_PH_OUT; // [RL7]
					end
				end
				cps_pkg::CPS_PH_OUT: begin
					phase_q <= cps_pkg::CPS_PH_IDLE;
				end
				cps_pkg::CPS_PH_IDLE: begin
					phase_q <= cps_pkg::CPS_PH_WAIT; // [RL8]
				end
				default: begin
					phase_q <= cps_pkg::CPS_PH_WAIT;
				end
			endcase
		end
	end

	// Send decisions; the pending flags and the inhibit timer act on these
	// at the same edge, so a change-triggered message goes out only once.
	assign dout_send = bus_ok && ((phase_q == cps_pkg::CPS_PH_OUT &&
		!dout_chg) || (dout_chg && dout_new_q &&
		gap_open && !sync_due)); // [RL7] [RL10] [RL11]
	assign aout_send = bus_ok && ((phase_q == cps_pkg::CPS_PH_OUT &&
		!aout_chg) || (aout_chg && aout_new_q && gap_open &&
		!dout_new_q && !sync_due)); // [RL10] [RL11] [RL12]

	// Transmit strobes to the one CAN controller, which keeps the single
	// bit rate shared by every party on the network.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_req <= 1'b0;
			dout_req <= 1'b0;
			aout_req <= 1'b0;
		end else begin
			sync_req <= sync_due; // [RL4] [RL19]
			dout_req <= dout_send;
			aout_req <= aout_send;
		end
	end

	// Output data registers reload from the written values on every clock.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dout_data <= 32'h00000000;
			aout_data <= 32'h00000000;
		end else begin
			dout_data <= dout_q;
			aout_data <= aout_q;
		end
	end

	// Inhibit timer restarts at every output send, periodic or change-triggered.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gap_cnt_q <= 16'h0000;
		end else if (dout_send || aout_send) begin
			gap_cnt_q <= gap_ms_q; // [RL12]
		end else if (ms_tick && gap_cnt_q != 16'h0000) begin
			gap_cnt_q <= gap_cnt_q - 16'h0001;
		end
	end

	// Pending change flags; a new write wins over the send clear.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dout_new_q <= 1'b0;
			aout_new_q <= 1'b0;
		end else begin
			if (wr && paddr == `CPS_OFF_DOUT) begin
				dout_new_q <= 1'b1; // [RL11]
			end else if (dout_send || !dout_chg) begin
				dout_new_q <= 1'b0;
			end
			if (wr && paddr == `CPS_OFF_AOUT) begin
				aout_new_q <= 1'b1; // [RL11]
			end else if (aout_send || !aout_chg) begin
				aout_new_q <= 1'b0;
			end
		end
	end

	// Software-written configuration and output values.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			enable_q <= 1'b0;
			sync_ms_q <= `CPS_SYNC_RST;
			gap_ms_q <= `CPS_GAP_RST;
			policy_q <= `CPS_POLICY_RST; // [RL3]
			dout_q <= 32'h00000000;
			aout_q <= 32'h00000000;
		end else if (wr) begin
			case (paddr)
				`CPS_OFF_CTRL: enable_q <= pwdata[0];
				`CPS_OFF_SYNC: sync_ms_q <= pwdata[15:0]; // [RL5]
				`CPS_OFF_GAP: gap_ms_q <= pwdata[15:0]; // [RL13]
				`CPS_OFF_POLICY: policy_q <= pwdata[3:0]; // [RL2]
				`CPS_OFF_DOUT: dout_q <= pwdata;
				`CPS_OFF_AOUT: aout_q <= pwdata;
				default: begin
				end
			endcase
		end
	end

	// Latest input data received from the nodes.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			din_q <= 32'h00000000;
			ain_q <= 32'h00000000;
		end else begin
			if (din_rx) begin
				din_q <= din_data; // [RL6]
			end
			if (ain_rx) begin
				ain_q <= ain_data;
			end
		end
	end

	// Error tallies, counting up on errors and down on successes.
	// They saturate, so a long error burst cannot wrap back to operational.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tec_q <= 9'h000;
			rec_q <= 9'h000;
		end else begin
			if (tx_err && tec_q != `CPS_TALLY_MAX) begin
				tec_q <= tec_q + 9'h001; // [RL15]
			end else if (tx_ok && !tx_err && tec_q != 9'h000) begin
				tec_q <= tec_q - 9'h001;
			end
			if (rx_err && rec_q != `CPS_TALLY_MAX) begin
				rec_q <= rec_q + 9'h001; // [RL15]
			end else if (rx_ok && !rx_err && rec_q != 9'h000) begin
				rec_q <= rec_q - 9'h001;
			end
		end
	end

	// Bus state machine; bus-off holds until reset.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_q <= cps_pkg::CPS_BUS_OPER;
		end else begin
			case (bus_q)
				cps_pkg::CPS_BUS_OPER, cps_pkg::CPS_BUS_PASSIVE: begin
					if (tec_q > `CPS_OFF_LIM) begin
						bus_q <= cps_pkg::CPS_BUS_OFF; // [RL18]
					end else if (tec_q > `CPS_PASSIVE_LIM ||
						rec_q > `CPS_PASSIVE_LIM) begin
						bus_q <= cps_pkg::CPS_BUS_PASSIVE; // [RL23]
					end else begin
						bus_q <= cps_pkg::CPS_BUS_OPER; // [RL23]
					end
				end
				cps_pkg::CPS_BUS_OFF: begin
					bus_q <= cps_pkg::CPS_BUS_OFF;
				end
				default: begin
					bus_q <= cps_pkg::CPS_BUS_OPER;
				end
			endcase
		end
	end

	// Participation controls follow the bus state.
	assign err_flag_en = (bus_q == cps_pkg::CPS_BUS_OPER); // [RL16] [RL17]
	assign bus_isolate = (bus_q == cps_pkg::CPS_BUS_OFF); // [RL18]

	// APB answers in the access cycle with no wait states.
	// Read data is latched in the setup cycle, so it stands at the access edge.
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (rd && !penable) begin
			case (paddr)
				`CPS_OFF_CTRL: prdata <= {31'h0, enable_q};
				`CPS_OFF_SYNC: prdata <= {16'h0000, sync_ms_q};
				`CPS_OFF_GAP: prdata <= {16'h0000, gap_ms_q};
				`CPS_OFF_POLICY: prdata <= {28'h0, policy_q};
				`CPS_OFF_STATUS: prdata <= {5'h00, bus_q,
					rec_q[7:0], 7'h00, tec_q}; // [RL22]
				`CPS_OFF_DOUT: prdata <= dout_q;
				`CPS_OFF_AOUT: prdata <= aout_q;
				`CPS_OFF_VER0: prdata <= {BOOT_VER, FW_VER}; // [RL21]
				`CPS_OFF_VER1: prdata <= {FW_REV, 8'h00, FW_SUB}; // [RL21]
				`CPS_OFF_NETCNT: prdata <= `CPS_NET_LIMIT; // [RL20]
				`CPS_OFF_DIN: prdata <= din_q;
				`CPS_OFF_AIN: prdata <= ain_q;
				default: prdata <= 32'h00000000;
			endcase
		end
	end

endmodule

// File: sim/cps_scheduler_props.sv
`timescale 1ns/1ns
module cps_scheduler_props (
	// Clock, reset and register writes.
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Message requests.
	input wire logic        sync_req,
	input wire logic        dout_req,
	input wire logic        aout_req,
	// Error events and bus state.
	input wire logic        tx_err,
	input wire logic        tx_ok,
	input wire logic        rx_err,
	input wire logic        rx_ok,
	input wire logic        err_flag_en,
	input wire logic        bus_isolate
);
	logic       pol_q;
	logic [8:0] tx_q;
	logic [8:0] rx_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Shadow of the digital output send policy.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pol_q <= 1'b0;
		end else if (psel && penable && pwrite && paddr == 12'h00C) begin
			pol_q <= pwdata[1];
		end
	end

	// Shadow tallies: an error wins over a success, both saturate.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_q <= 9'h000;
			rx_q <= 9'h000;
		end else begin
			if (tx_err && tx_q != 9'h1FF) tx_q <= tx_q + 9'h001;
			else if (!tx_err && tx_ok && tx_q != 9'h000) tx_q <= tx_q - 9'h001;
			if (rx_err && rx_q != 9'h1FF) rx_q <= rx_q + 9'h001;
			else if (!rx_err && rx_ok && rx_q != 9'h000) rx_q <= rx_q - 9'h001;
		end
	end

	a_sync_gap: assert property (sync_req |=> !sync_req [*8])
		else $error("sync messages too close");
	a_synced_out: assert property (sync_req && !pol_q |=> dout_req)
		else $error("output message missing after sync");
	a_out_gap: assert property ((dout_req || aout_req) |=>
		!(dout_req || aout_req) [*8]) else $error("output messages too close");
	a_off_quiet: assert property (bus_isolate |->
		!(sync_req || dout_req || aout_req)) else $error("send in bus-off");
	a_off_holds: assert property (!$fell(bus_isolate))
		else $error("bus-off left without reset");
	a_off_entry: assert property (tx_q > 9'h0FF |-> ##[0:2] bus_isolate)
		else $error("bus-off not entered");
	a_passive_entry: assert property ((tx_q > 9'h07F || rx_q > 9'h07F)
		|-> ##[0:2] !err_flag_en) else $error("passive not entered");
	a_oper_return: assert property ((tx_q <= 9'h07F && rx_q <= 9'h07F
		&& !bus_isolate) [*3] |-> err_flag_en) else $error("not operational");
	a_off_no_flags: assert property (bus_isolate |-> !err_flag_en)
		else $error("error flags while isolated");
endmodule

bind cps_scheduler cps_scheduler_props u_props (.mclk(mclk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .sync_req(sync_req), .dout_req(dout_req),
	.aout_req(aout_req), .tx_err(tx_err), .tx_ok(tx_ok), .rx_err(rx_err),
	.rx_ok(rx_ok), .err_flag_en(err_flag_en), .bus_isolate(bus_isolate));

// File: sim/cps_node_model.sv
`timescale 1ns/1ns
module cps_node_model (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Master traffic and live node inputs.
	input  wire logic        sync_req,
	input  wire logic        dout_req,
	input  wire logic        aout_req,
	input  wire logic [31:0] dv,
	input  wire logic [31:0] av,
	// Node traffic back to the master.
	output logic             din_rx,
	output logic             ain_rx,
	output logic      [31:0] din_data,
	output logic      [31:0] ain_data,
	output logic             tx_done
);
	logic [31:0] ld_q;
	logic [31:0] la_q;
	logic [1:0]  cnt_q;

	// Latch inputs at each sync and send them back shortly after.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 2'h0;
			ld_q <= 32'h0;
			la_q <= 32'h0;
			din_rx <= 1'b0;
			ain_rx <= 1'b0;
			din_data <= 32'h0;
			ain_data <= 32'h0;
			tx_done <= 1'b0;
		end else begin
			din_rx <= 1'b0;
			ain_rx <= 1'b0;
			din_data <= ~din_data; // Released data changes every cycle.
			ain_data <= ~ain_data;
			tx_done <= sync_req | dout_req | aout_req;
			if (sync_req) begin
				ld_q <= dv;
				la_q <= av;
				cnt_q <= 2'h3;
			end else if (cnt_q != 2'h0) begin
				cnt_q <= cnt_q - 2'h1;
			end
			if (cnt_q == 2'h2) begin
				din_rx <= 1'b1;
				din_data <= ld_q;
			end
			if (cnt_q == 2'h1) begin
				ain_rx <= 1'b1;
				ain_data <= la_q;
			end
		end
	end
endmodule

// File: sim/cps_scheduler_bench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module cps_scheduler_bench;
	logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic        tx_err = 0, tx_ok = 0, rx_err = 0, rx_ok = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, dv = 0, av = 0, w, ev;
	wire  [31:0] prdata, dout_data, aout_data, din_data, ain_data;
	wire         pready, sync_req, dout_req, aout_req, tx_done, din_rx;
	wire         ain_rx, err_flag_en, bus_isolate, pslverr;
	int          n_mismatch = 0, checks_done = 0, n_dout = 0;
	time         t0;
	logic [31:0] rq[$], dq[$], aq[$];

	// Free-running 100 MHz clock.
	always #5 mclk = ~mclk;

	cps_scheduler #(.CYC_PER_MS(10)) u_cps_scheduler (.mclk(mclk),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sync_req(sync_req), .dout_req(dout_req),
		.aout_req(aout_req), .dout_data(dout_data), .aout_data(aout_data),
		.tx_done(tx_done), .din_rx(din_rx), .ain_rx(ain_rx),
		.din_data(din_data), .ain_data(ain_data), .tx_err(tx_err),
		.tx_ok(tx_ok), .rx_err(rx_err), .rx_ok(rx_ok),
		.err_flag_en(err_flag_en), .bus_isolate(bus_isolate));
	cps_node_model u_cps_node_model (.mclk(mclk), .rst_n(rst_n),
		.sync_req(sync_req), .dout_req(dout_req), .aout_req(aout_req),
		.dv(dv), .av(av), .din_rx(din_rx), .ain_rx(ain_rx),
		.din_data(din_data), .ain_data(ain_data), .tx_done(tx_done));

	// Takes the oldest expectation as each result appears.
	always @(posedge mclk) begin
		if (psel && penable && pready && !pwrite && rq.size() > 0) begin
			ev = rq.pop_front();
			`CHK(prdata, ev)
		end
		if (psel && penable && pready) `CHK(pslverr, 1'b0)
		if (dout_req) n_dout++;
		if (dout_req && dq.size() > 0) begin
			ev = dq.pop_front();
			`CHK(dout_data, ev)
		end
		if (aout_req && aq.size() > 0) begin
			ev = aq.pop_front();
			`CHK(aout_data, ev)
		end
	end

	// One register access, held until ready is seen.
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	// Error events, one per cycle.
	task pulse(input logic [3:0] m, input int n);
		repeat (n) begin @(posedge mclk); {tx_err, tx_ok, rx_err, rx_ok} <= m; end
		@(posedge mclk);
		{tx_err, tx_ok, rx_err, rx_ok} <= 4'h0;
		repeat (3) @(posedge mclk);
	endtask

	// Waits for the next sync request; only the watchdog bounds the wait.
	task wsync;
		@(posedge mclk);
		while (sync_req !== 1'b1) @(posedge mclk);
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence.
	initial begin
		void'($urandom(43929));
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		rd(12'h004, 32'h0000000A);
		rd(12'h008, 32'h00000005);
		rd(12'h00C, 32'h00000000);
		rd(12'h010, 32'h01000000);
		rd(12'h024, 32'h00000001);
		rd(12'h01C, 32'h00010001);
		rd(12'h020, 32'h01000001);
		rd(12'h030, 32'h00000000);
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, 12'h00C, i);
			rd(12'h00C, i);
		end
		$display("test registers done");
		dv <= $urandom;
		av <= $urandom;
		w = $urandom;
		dq.push_back(w);
		apb(1'b1, 12'h00C, 32'h0);
		apb(1'b1, 12'h004, 32'h4);
		apb(1'b1, 12'h008, 32'h2);
		apb(1'b1, 12'h014, w);
		w = $urandom;
		aq.push_back(w);
		apb(1'b1, 12'h018, w);
		apb(1'b1, 12'h000, 32'h1);
		wsync;
		t0 = $time;
		wsync;
		`CHK(($time - t0) / 10, 40)
		repeat (8) @(posedge mclk);
		rd(12'h028, dv);
		rd(12'h02C, av);
		$display("test periodic done");
		apb(1'b1, 12'h00C, 32'hA);
		wsync;
		repeat (3) @(posedge mclk);
		n_dout = 0;
		repeat (45) @(posedge mclk);
		`CHK(n_dout, 0)
		w = $urandom;
		dq.push_back(w);
		apb(1'b1, 12'h014, w);
		w = $urandom;
		aq.push_back(w);
		apb(1'b1, 12'h018, w);
		repeat (60) @(posedge mclk);
		`CHK(n_dout, 1)
		`CHK(aq.size() + dq.size(), 0)
		$display("test change done");
		pulse(4'h2, 128);
		rd(12'h010, 32'h02800000);
		`CHK(err_flag_en, 1'b0)
		pulse(4'h1, 1);
		rd(12'h010, 32'h017F0000);
		`CHK(err_flag_en, 1'b1)
		pulse(4'h8, 256);
		rd(12'h010, 32'h047F0100);
		`CHK({err_flag_en, bus_isolate}, 2'b01)
		repeat (40) @(posedge mclk);
		$display("test errors done");
		close_out;
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#200000;
		n_mismatch++;
		close_out;
	end
endmodule
